// ==== codec_regs.svh ====
`ifndef CODEC_REGS_SVH
`define CODEC_REGS_SVH

`define NIB_W 4
`define WORD_W 6
`define SCR_LEN 23
`define SCR_TAP 18
`define DSCR_TAP 5
`define FIFO_DEPTH 8
`define SUM_MIN 4'sh1
`define SUM_MAX 4'sh4
`define SUM_HIGH_LOAD 4'sh3
`define SUM_LOW_LOAD 4'sh1
`define COL_RESET 4'sh1
`define POS_FIRST 2'h0
`define POS_SECOND 2'h1
`define POS_THIRD 2'h2

`endif

// ==== codec_pkg.sv ====
`include "codec_regs.svh"

package codec_pkg;

    typedef enum logic [1:0] {
        SYM_ZERO = 2'b00,
        SYM_PLUS = 2'b01,
        SYM_MINUS = 2'b11
    } sym_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SYM0 = 2'b01,
        TX_SYM1 = 2'b10,
        TX_SYM2 = 2'b11
    } tx_state_t;

    typedef struct packed {
        tx_state_t tx_state;
        logic [`WORD_W-1:0] tx_word;
        logic signed [3:0] tx_col;
        logic [`SCR_LEN-1:0] scr;
        logic [1:0] tx_sym;
        logic tx_sym_valid;
        logic [1:0] rx_pos;
        logic [`WORD_W-1:0] rx_word;
        logic signed [3:0] running_polarity_sum;
        logic [`SCR_LEN-1:0] dscr;
        logic [`NIB_W-1:0] rx_nibble;
        logic rx_nibble_valid;
        logic violation;
    } codec_state_t;

endpackage : codec_pkg

// ==== codec_fifo_if.sv ====
interface codec_fifo_if #(
    parameter int WIDTH = 4
);
    logic [WIDTH-1:0] in_data;
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] out_data;
    logic out_valid;
    logic out_ready;

    modport buffer (
        input in_data,
        input in_valid,
        output in_ready,
        output out_data,
        output out_valid,
        input out_ready
    );

    modport user (
        output in_data,
        output in_valid,
        input in_ready,
        input out_data,
        input out_valid,
        output out_ready
    );
endinterface : codec_fifo_if

// ==== codec_fifo.sv ====
module codec_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    codec_fifo_if.buffer port
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [CNT_W-1:0] count;
        logic in_ready;
    } fifo_state_t;

    fifo_state_t s_q;
    fifo_state_t s_d;
    logic push;
    logic pop;

    // Ready is registered, so it is judged from the count after this edge
    always_comb
    begin
        s_d = s_q;
        push = port.in_valid && s_q.in_ready;
        pop = port.out_ready && (s_q.count != '0);
        if (push)
        begin
            s_d.mem[s_q.wr_ptr] = port.in_data;
            s_d.wr_ptr = s_q.wr_ptr + PTR_W'(1);
        end
        if (pop)
        begin
            s_d.rd_ptr = s_q.rd_ptr + PTR_W'(1);
        end
        if (push && !pop)
        begin
            s_d.count = s_q.count + CNT_W'(1);
        end
        else if (pop && !push)
        begin
            s_d.count = s_q.count - CNT_W'(1);
        end
        s_d.in_ready = s_d.count < CNT_W'(DEPTH);
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            s_q <= '{mem: '0, wr_ptr: '0, rd_ptr: '0, count: '0, in_ready: 1'b1};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign port.in_ready = s_q.in_ready;
    assign port.out_valid = s_q.count != '0;
    assign port.out_data = s_q.mem[s_q.rd_ptr];

endmodule : codec_fifo

// ==== ternary_block_line_codec.sv ====
// Operation
// R1 - Encode each 4-bit block into 3 ternary symbols
// R2 - Column state picks code column, table gives next
// R3 - Leftmost binary bit and symbol go first
// R4 - Only table words emitted, never all-zero
// R5 - Decode each 3-symbol group into 4 bits
// R6 - Any column's word decodes regardless of state
// R7 - Leftmost received symbol first, leftmost bit out first
// R8 - All-zero ternary word decodes to 0000
// R9 - Running sum adds polarity of each symbol
// R10 - Sum at word end is next expected column
// R11 - Violation when sum below one or above four
// R12 - Violation when word is three zero symbols
// R13 - Error-free word keeps running sum unchanged
// R14 - Sum above four reloads to three
// R15 - Sum zero or negative reloads to one
// R16 - Transmit data scrambled before the encoder
// R17 - Scrambler taps at delays 23 and 18
// R18 - Decoded data descrambled before forwarding
// R19 - Descrambler taps at delays 23 and 5
// R20 - Descrambler self-synchronises after 23 symbols; the code's 23-bit shifter syncs after 23 decoded bits
// R21 - Maintenance bit not reachable through frame interface
// R22 - Reset: column one, sum one, shifters cleared
// R23 - Violation is a one-cycle pulse at word end
`include "codec_regs.svh"

module ternary_block_line_codec
    import codec_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [`NIB_W-1:0] tx_nibble_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    output logic [1:0] tx_sym_out,
    output logic tx_sym_valid_out,
    input wire logic tx_sym_ready_in,
    input wire logic [1:0] rx_sym_in,
    input wire logic rx_sym_valid_in,
    input wire logic rx_word_start_in,
    output logic [`NIB_W-1:0] rx_nibble_out,
    output logic rx_nibble_valid_out,
    output logic code_violation_out
);
    localparam logic [1:0] P = SYM_PLUS;
    localparam logic [1:0] Z = SYM_ZERO;
    localparam logic [1:0] M = SYM_MINUS;

    localparam codec_state_t RESET_STATE = '{
        tx_state: TX_IDLE,
        tx_word: '0,
        tx_col: `COL_RESET,
        scr: '0,
        tx_sym: SYM_ZERO,
        tx_sym_valid: 1'b0,
        rx_pos: `POS_FIRST,
        rx_word: '0,
        running_polarity_sum: `COL_RESET,
        dscr: '0,
        rx_nibble: '0,
        rx_nibble_valid: 1'b0,
        violation: 1'b0
    };

    codec_state_t s_q;
    codec_state_t s_d;
    logic [`NIB_W-1:0] scr_nibble;
    logic [`SCR_LEN-1:0] scr_next;
    logic pop_ok;

    codec_fifo_if #(.WIDTH(`NIB_W)) tx_fifo ();

    codec_fifo #(
        .WIDTH(`NIB_W),
        .DEPTH(`FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .port(tx_fifo.buffer)
    );

    function automatic logic signed [3:0] polarity(input logic [1:0] sym);
        case (sym)
            P: polarity = 4'sh1;
            M: polarity = -4'sh1;
            default: polarity = 4'sh0;
        endcase
    endfunction : polarity

    function automatic logic signed [3:0] weight(input logic [`WORD_W-1:0] w);
        weight = polarity(w[5:4]) + polarity(w[3:2]) + polarity(w[1:0]);
    endfunction : weight

    // Table words only; the next column is the current one plus word weight
    function automatic logic [`WORD_W-1:0] encode(input logic [`NIB_W-1:0] nib, input logic signed [3:0] col);
        logic first;
        logic low;
        logic last;
        first = col == `COL_RESET;
        low = col < `SUM_HIGH_LOAD;
        last = col == `SUM_MAX;
        case (nib)
            4'h1: encode = {Z, M, P};
            4'h7: encode = {M, Z, P};
            4'h4: encode = {M, P, Z};
            4'h2: encode = {P, M, Z};
            4'hb: encode = {P, Z, M};
            4'he: encode = {Z, P, M};
            4'h9: encode = last ? {M, M, M} : {P, M, P};
            4'h3: encode = last ? {M, M, Z} : {Z, Z, P};
            4'hd: encode = last ? {M, Z, M} : {Z, P, Z};
            4'h8: encode = last ? {Z, M, M} : {P, Z, Z};
            4'h6: encode = low ? {M, P, P} : {M, M, P};
            4'ha: encode = low ? {P, P, M} : {P, M, M};
            4'hf: encode = first ? {P, P, Z} : {Z, Z, M};
            4'h0: encode = first ? {P, Z, P} : {Z, M, Z};
            4'h5: encode = first ? {Z, P, P} : {M, Z, Z};
            default: encode = first ? {P, P, P} : {M, P, M};
        endcase
    endfunction : encode

    // Column-free inverse: every word of every column has one meaning
    function automatic logic [`NIB_W-1:0] decode(input logic [`WORD_W-1:0] w);
        case (w)
            {Z, M, P}: decode = 4'h1;
            {M, Z, P}: decode = 4'h7;
            {M, P, Z}: decode = 4'h4;
            {P, M, Z}: decode = 4'h2;
            {P, Z, M}: decode = 4'hb;
            {Z, P, M}: decode = 4'he;
            {P, M, P}: decode = 4'h9;
            {M, M, M}: decode = 4'h9;
            {Z, Z, P}: decode = 4'h3;
            {M, M, Z}: decode = 4'h3;
            {Z, P, Z}: decode = 4'hd;
            {M, Z, M}: decode = 4'hd;
            {P, Z, Z}: decode = 4'h8;
            {Z, M, M}: decode = 4'h8;
            {M, P, P}: decode = 4'h6;
            {M, M, P}: decode = 4'h6;
            {P, P, M}: decode = 4'ha;
            {P, M, M}: decode = 4'ha;
            {P, P, Z}: decode = 4'hf;
            {Z, Z, M}: decode = 4'hf;
            {P, Z, P}: decode = 4'h0;
            {Z, M, Z}: decode = 4'h0;
            {Z, P, P}: decode = 4'h5;
            {M, Z, Z}: decode = 4'h5;
            {P, P, P}: decode = 4'hc;
            {M, P, M}: decode = 4'hc;
            default: decode = 4'h0;
        endcase
    endfunction : decode

    // Bit 3 of a nibble is its leftmost, earliest bit
    always_comb
    begin
        scr_next = s_q.scr;
        scr_nibble = '0;
        for (int i = `NIB_W - 1; i >= 0; i--)
        begin
            scr_nibble[i] = tx_nibble_in[i] ^ scr_next[`SCR_TAP-1] ^ scr_next[`SCR_LEN-1]; // see R17 R3
            scr_next = {scr_next[`SCR_LEN-2:0], scr_nibble[i]};
        end
    end

    // Only 2B+D nibbles enter; no maintenance bit path exists here, see R21
    assign tx_fifo.in_data = scr_nibble; // see R16
    assign tx_fifo.in_valid = tx_valid_in;

    // Back-to-back words: the next pop may replace the last symbol in place
    assign pop_ok = (s_q.tx_state == TX_IDLE) || ((s_q.tx_state == TX_SYM2) && tx_sym_ready_in);
    assign tx_fifo.out_ready = pop_ok;

    always_comb
    begin
        logic [`WORD_W-1:0] full_word;
        logic [`NIB_W-1:0] dec;
        logic [`SCR_LEN-1:0] dreg;
        logic signed [3:0] sum;
        logic [1:0] pos;
        full_word = '0;
        dec = '0;
        dreg = s_q.dscr;
        sum = s_q.running_polarity_sum;
        pos = s_q.rx_pos;
        s_d = s_q;
        s_d.rx_nibble_valid = 1'b0;
        s_d.violation = 1'b0; // see R23

        if (tx_valid_in && tx_fifo.in_ready)
        begin
            s_d.scr = scr_next; // see R16
        end

        case (s_q.tx_state)
            TX_IDLE:
            begin
                s_d.tx_sym_valid = 1'b0;
            end
            TX_SYM0:
            begin
                if (tx_sym_ready_in)
                begin
                    s_d.tx_sym = s_q.tx_word[3:2]; // see R3
                    s_d.tx_state = TX_SYM1;
                end
            end
            TX_SYM1:
            begin
                if (tx_sym_ready_in)
                begin
                    s_d.tx_sym = s_q.tx_word[1:0]; // see R3
                    s_d.tx_state = TX_SYM2;
                end
            end
            TX_SYM2:
            begin
                if (tx_sym_ready_in)
                begin
                    s_d.tx_sym_valid = 1'b0;
                    s_d.tx_state = TX_IDLE;
                end
            end
            default:
            begin
                s_d.tx_sym_valid = 1'b0;
                s_d.tx_state = TX_IDLE;
            end
        endcase

        if (pop_ok && tx_fifo.out_valid)
        begin
            s_d.tx_word = encode(tx_fifo.out_data, s_q.tx_col); // see R1 R4
            s_d.tx_col = s_q.tx_col + weight(s_d.tx_word); // see R2
            s_d.tx_sym = s_d.tx_word[5:4]; // see R3
            s_d.tx_sym_valid = 1'b1;
            s_d.tx_state = TX_SYM0;
        end

        // Word alignment comes from the framer; without it, words follow on
        if (rx_sym_valid_in)
        begin
            if (rx_word_start_in)
            begin
                pos = `POS_FIRST;
            end
            sum = s_q.running_polarity_sum + polarity(rx_sym_in); // see R9
            s_d.running_polarity_sum = sum;
            case (pos)
                `POS_FIRST:
                begin
                    s_d.rx_word[5:4] = rx_sym_in; // see R7
                    s_d.rx_pos = `POS_SECOND;
                end
                `POS_SECOND:
                begin
                    s_d.rx_word[3:2] = rx_sym_in;
                    s_d.rx_pos = `POS_THIRD;
                end
                default:
                begin
                    full_word = {s_q.rx_word[5:2], rx_sym_in};
                    dec = decode(full_word); // see R5 R6 R8
                    for (int i = `NIB_W - 1; i >= 0; i--)
                    begin
                        s_d.rx_nibble[i] = dec[i] ^ dreg[`DSCR_TAP-1] ^ dreg[`SCR_LEN-1]; // see R18 R19 R7
                        dreg = {dreg[`SCR_LEN-2:0], dec[i]}; // see R20
                    end
                    s_d.dscr = dreg;
                    s_d.rx_nibble_valid = 1'b1;
                    // Sum left at word end names the next column expected, see R10
                    // Unused code 2'b10 has no polarity, so only bit 0 of each symbol matters
                    s_d.violation = (sum < `SUM_MIN) || (sum > `SUM_MAX)
                        || ({full_word[4], full_word[2], full_word[0]} == 3'h0); // see R11 R12 R23
                    // Correction stored now equals loading it at the next word start
                    if (sum > `SUM_MAX)
                    begin
                        s_d.running_polarity_sum = `SUM_HIGH_LOAD; // see R14
                    end
                    else if (sum < `SUM_MIN)
                    begin
                        s_d.running_polarity_sum = `SUM_LOW_LOAD; // see R15
                    end
                    else
                    begin
                        s_d.running_polarity_sum = sum; // see R13
                    end
                    s_d.rx_pos = `POS_FIRST;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            s_q <= RESET_STATE; // see R22
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign tx_ready_out = tx_fifo.in_ready;
    assign tx_sym_out = s_q.tx_sym;
    assign tx_sym_valid_out = s_q.tx_sym_valid;
    assign rx_nibble_out = s_q.rx_nibble;
    assign rx_nibble_valid_out = s_q.rx_nibble_valid;
    assign code_violation_out = s_q.violation;

endmodule : ternary_block_line_codec

// ==== codec_monitor.sv ====
`include "codec_regs.svh"

module codec_monitor (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [`NIB_W-1:0] tx_nibble_in,
    input wire logic tx_valid_in,
    input wire logic tx_ready_out,
    input wire logic [1:0] tx_sym_out,
    input wire logic tx_sym_valid_out,
    input wire logic tx_sym_ready_in,
    input wire logic [1:0] rx_sym_in,
    input wire logic rx_sym_valid_in,
    input wire logic rx_word_start_in,
    input wire logic [`NIB_W-1:0] rx_nibble_out,
    input wire logic rx_nibble_valid_out,
    input wire logic code_violation_out
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [1:0] pos; logic zz; logic signed [3:0] col;} mon_t;
    mon_t mon_q, mon_d;
    logic take;
    logic signed [3:0] col_next;
    assign take = tx_sym_valid_out && tx_sym_ready_in;
    assign col_next = mon_q.col + (tx_sym_out == 2'h1 ? 4'sh1 : tx_sym_out == 2'h3 ? 4'shf : 4'sh0);
    // Shadow of the sent stream: word position, leading zeros, column
    always_comb
    begin
        mon_d = mon_q;
        if (take)
        begin
            mon_d.pos = mon_q.pos == 2'h2 ? 2'h0 : mon_q.pos + 2'h1;
            mon_d.zz = mon_q.pos != 2'h2 && (mon_q.pos == 2'h0 || mon_q.zz) && tx_sym_out == 2'h0;
            mon_d.col = col_next;
        end
    end
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            mon_q <= '{pos: 2'h0, zz: 1'h0, col: `COL_RESET};
        else
            mon_q <= mon_d;
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    sequence word_s;
        rx_sym_valid_in && rx_word_start_in ##1 (rx_sym_valid_in && !rx_word_start_in) [*2];
    endsequence
    sequence zero_word_s;
        rx_sym_valid_in && rx_word_start_in && !rx_sym_in[0] ##1
            (rx_sym_valid_in && !rx_word_start_in && !rx_sym_in[0]) [*2];
    endsequence
    a_word_gives_nibble: assert property (word_s |=> rx_nibble_valid_out)
        else $error("no block after a full word");
    a_zero_word_flag: assert property (zero_word_s |=> code_violation_out)
        else $error("all-zero word not flagged");
    a_flag_with_block: assert property (code_violation_out |-> rx_nibble_valid_out)
        else $error("violation without block");
    a_block_pulse_once: assert property (rx_nibble_valid_out |=> !rx_nibble_valid_out [*2])
        else $error("block valid not a pulse");
    a_sym_held: assert property (tx_sym_valid_out && !tx_sym_ready_in |=> tx_sym_valid_out && $stable(tx_sym_out))
        else $error("symbol changed before taken");
    a_no_zero_word: assert property (take && mon_q.pos == 2'h2 && mon_q.zz |-> tx_sym_out != 2'h0)
        else $error("all-zero word sent");
    a_column_range: assert property (take && mon_q.pos == 2'h2 |-> col_next >= 4'sh1 && col_next <= 4'sh4)
        else $error("column left range");
    a_first_symbol: assert property (!tx_sym_valid_out && tx_valid_in && tx_ready_out |-> ##[1:2] tx_sym_valid_out)
        else $error("taken block not sent in time");
endmodule : codec_monitor

bind ternary_block_line_codec codec_monitor mon (.clk_in, .rst_b_in, .tx_nibble_in, .tx_valid_in, .tx_ready_out,
    .tx_sym_out, .tx_sym_valid_out, .tx_sym_ready_in, .rx_sym_in, .rx_sym_valid_in, .rx_word_start_in,
    .rx_nibble_out, .rx_nibble_valid_out, .code_violation_out);

// ==== line_front_end_model.sv ====
module line_front_end_model (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [1:0] sym_in,
    input wire logic sym_valid_in,
    input wire logic hold_in,
    input wire logic slow_in,
    output logic sym_ready_out,
    output logic [1:0] rx_sym_out,
    output logic rx_valid_out,
    output logic rx_start_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] pos_q;
    logic ph_q;
    always @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pos_q <= 2'h0;
            ph_q <= 1'h0;
            sym_ready_out <= 1'h0;
            rx_sym_out <= 2'h0;
            rx_valid_out <= 1'h0;
            rx_start_out <= 1'h0;
        end
        else
        begin
            ph_q <= !ph_q;
            // Slow mode takes every other cycle
            sym_ready_out <= !hold_in && (!slow_in || ph_q);
            // Loop taken symbols back in order
            rx_valid_out <= sym_valid_in && sym_ready_out;
            rx_start_out <= sym_valid_in && sym_ready_out && pos_q == 2'h0;
            // Idle line inverts its last value each cycle, so it alternates between the inverse and a stale copy of the last symbol
            rx_sym_out <= (sym_valid_in && sym_ready_out) ? sym_in : ~rx_sym_out;
            if (sym_valid_in && sym_ready_out)
                pos_q <= (pos_q == 2'h2) ? 2'h0 : pos_q + 2'h1;
        end
    end
endmodule : line_front_end_model

// ==== tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, rst_b_in, tx_valid_in, tx_ready_out, tx_sym_valid_out, tx_sym_ready_in, rx_nibble_valid_out;
    logic code_violation_out, rx_sym_valid_in, rx_word_start_in, lp_valid, lp_start, inj_valid, inj_start, hold, slow;
    logic [3:0] tx_nibble_in, rx_nibble_out;
    logic [1:0] tx_sym_out, rx_sym_in, lp_sym, inj_sym;
    logic [31:0] rnd = 32'hfe71;
    logic [22:0] tx_h, rx_h;
    logic [4:0] exp_q [$];
    int err_total = 0, total_checks = 0, n;
    // Word, decoded block, violation: sums and reloads starting from column one
    logic [10:0] inj_tab [0:6] = '{{6'h00, 4'h0, 1'h1}, {6'h15, 4'hc, 1'h0}, {6'h15, 4'hc, 1'h1},
        {6'h3f, 4'h9, 1'h1}, {6'h0c, 4'h0, 1'h1}, {6'h11, 4'h0, 1'h0}, {6'h07, 4'he, 1'h0}};
    assign rx_sym_in = inj_valid ? inj_sym : lp_sym;
    assign rx_sym_valid_in = inj_valid | lp_valid;
    assign rx_word_start_in = inj_valid ? inj_start : lp_start;
    ternary_block_line_codec DUT (.clk_in, .rst_b_in, .tx_nibble_in, .tx_valid_in, .tx_ready_out, .tx_sym_out,
        .tx_sym_valid_out, .tx_sym_ready_in, .rx_sym_in, .rx_sym_valid_in, .rx_word_start_in, .rx_nibble_out,
        .rx_nibble_valid_out, .code_violation_out);
    line_front_end_model far (.clk_in, .rst_b_in, .sym_in(tx_sym_out), .sym_valid_in(tx_sym_valid_out),
        .hold_in(hold), .slow_in(slow), .sym_ready_out(tx_sym_ready_in), .rx_sym_out(lp_sym),
        .rx_valid_out(lp_valid), .rx_start_out(lp_start));
    initial
    begin
        clk_in = 1'h0;
        forever #5 clk_in = ~clk_in;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        total_checks++;
        if (seen !== want)
        begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic expect_word(input logic [3:0] d, input logic v);
        logic [3:0] o;
        for (int i = 3; i >= 0; i--)
        begin
            o[i] = d[i] ^ rx_h[4] ^ rx_h[22];
            rx_h = {rx_h[21:0], d[i]};
        end
        exp_q.push_back({v, o});
    endtask : expect_word
    task automatic send(input logic [3:0] d);
        logic [3:0] s;
        @(negedge clk_in);
        tx_valid_in = 1'h1;
        tx_nibble_in = d;
        // Ready is a register, so it is settled here and decides the next edge
        if (tx_ready_out === 1'h1)
        begin
            n++;
            for (int i = 3; i >= 0; i--)
            begin
                s[i] = d[i] ^ tx_h[17] ^ tx_h[22];
                tx_h = {tx_h[21:0], s[i]};
            end
            expect_word(s, 1'h0);
        end
    endtask : send
    task automatic do_reset;
        @(negedge clk_in);
        rst_b_in = 1'h0;
        tx_h = '0;
        rx_h = '0;
        repeat (8) @(posedge clk_in);
        @(negedge clk_in);
        rst_b_in = 1'h1;
    endtask : do_reset
    task automatic drain;
        for (int k = 0; k < 400 && exp_q.size() != 0; k++)
            @(negedge clk_in);
        check(8'(exp_q.size()), 8'h0);
    endtask : drain
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    always @(negedge clk_in)
    begin
        if (rx_nibble_valid_out === 1'h1)
        begin
            if (exp_q.size() == 0)
                check(8'h1, 8'h0);
            else
                check({3'h0, code_violation_out, rx_nibble_out}, {3'h0, exp_q.pop_front()});
        end
    end
    initial
    begin
        repeat (5000) @(posedge clk_in);
        err_total++;
        print_verdict();
    end
    initial
    begin
        rst_b_in = 1'h0;
        tx_valid_in = 1'h0;
        tx_nibble_in = 4'h0;
        inj_valid = 1'h0;
        inj_start = 1'h0;
        inj_sym = 2'h0;
        hold = 1'h0;
        slow = 1'h0;
        n = 0;
        do_reset();
        foreach (inj_tab[k])
        begin
            for (int i = 0; i < 3; i++)
            begin
                @(negedge clk_in);
                inj_valid = 1'h1;
                inj_start = (i == 0);
                inj_sym = inj_tab[k][10 - 2 * i -: 2];
            end
            expect_word(inj_tab[k][4:1], inj_tab[k][0]);
        end
        @(negedge clk_in);
        inj_valid = 1'h0;
        drain();
        $display("test monitor done");
        // Second reset mid-run: column, sum and shifters restart
        do_reset();
        repeat (60)
        begin
            rnd = lfsr_next(rnd);
            slow = rnd[5];
            if (rnd[6])
                send(rnd[3:0]);
            else
            begin
                @(negedge clk_in);
                tx_valid_in = 1'h0;
            end
        end
        @(negedge clk_in);
        tx_valid_in = 1'h0;
        drain();
        $display("test loopback done");
        hold = 1'h1;
        n = 0;
        // Offers beyond the buffer are refused and must never reach the line
        for (int k = 0; k < 12; k++)
        begin
            rnd = lfsr_next(rnd);
            send(rnd[3:0]);
        end
        @(negedge clk_in);
        tx_valid_in = 1'h0;
        check(8'(n), 8'h9);
        hold = 1'h0;
        slow = 1'h1;
        drain();
        $display("test buffer done");
        print_verdict();
    end
endmodule : tb_top
